// ==== tfmc_pkg.sv ====
// Purpose: constants for triggered frame mode control
// Assumes: one camera clock at 100 MHz
// Notes: frame timing counts are defaults, overridable at top
package tfmc_pkg;

  // operating modes
  typedef enum logic [1:0] {
    TFMC_MODE_FREE,
    TFMC_MODE_FAST,
    TFMC_MODE_PRECISE
  } tfmc_mode_t;

  // clock rate
  localparam int CLK_HZ = 100000000;
  // frame period in microseconds, about 9.3 fps
  localparam int FRAME_PERIOD_US = 107527;
  localparam int FRAME_CYCLES = (FRAME_PERIOD_US / 1000) * (CLK_HZ / 1000);
  // exposure window start and length within a frame, microseconds
  localparam int EXP_START_US = 2000;
  localparam int EXP_START_CYCLES = EXP_START_US * (CLK_HZ / 1000000);
  localparam int EXP_LEN_US = 2500;
  localparam int EXP_LEN_CYCLES = EXP_LEN_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 32;

endpackage

// ==== tfmc_frame_timer.sv ====
// Purpose: free-running frame cycle counter with restart
// Assumes: restart is a same-clock pulse
// Notes: produces frame start and exposure window flags
`timescale 1ns/1ns
module tfmc_frame_timer #(
  parameter int FRAME_CYC = 1000,
  parameter int EXP_START = 10,
  parameter int EXP_LEN = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic restart,
  // status
  output logic frameStart,
  output logic expStart,
  output logic expEnd,
  output logic expActive
);

  logic [31:0] cnt_reg;

  // ----------------------------------------
  // frame counter
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_reg <= 32'h0000_0000;
    end else if (restart || cnt_reg == 32'(FRAME_CYC - 1)) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  assign frameStart = (cnt_reg == 32'h0000_0000);
  assign expStart = (cnt_reg == 32'(EXP_START));
  assign expEnd = (cnt_reg == 32'(EXP_START + EXP_LEN - 1));
  assign expActive = (cnt_reg >= 32'(EXP_START)) && (cnt_reg < 32'(EXP_START + EXP_LEN));

endmodule

// ==== tfmc_top.sv ====
// Purpose: turns trigger events into delivered frames per mode
// Assumes: trigger pin is asynchronous; mode is static during use
// Notes: frame delivery marked by deliver pulse at exposure end
`timescale 1ns/1ns

// Summary of operation
// - free, fast and precise modes by one setting
// - free mode delivers every frame, ignores trigger
// - fast mode sensor keeps cycling natively
// - fast trigger: finish exposure, deliver next
// - trigger before exposure: deliver this cycle
// - trigger after exposure start: deliver next cycle
// - fast trigger latency up to one frame
// - precise trigger restarts frame cycle
// - precise: drop first frame, deliver second
// - delivered exposure starts one frame plus EXP_START plus one cycle after trigger
// - precise rate up to one delivery per frame plus EXP_START plus EXP_LEN plus one cycle
module tfmc_top #(
  parameter int FRAME_CYC = tfmc_pkg::FRAME_CYCLES,
  parameter int EXP_START = tfmc_pkg::EXP_START_CYCLES,
  parameter int EXP_LEN = tfmc_pkg::EXP_LEN_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // mode setting
  input wire tfmc_pkg::tfmc_mode_t modeSel,
  // external trigger pin
  input wire logic triggerIn,
  // exposure output
  output logic exposureOut,
  // frame cycle status
  output logic frameStart,
  output logic sensorExposing,
  // delivery path
  output logic frameDeliver,
  output logic frameDrop,
  output logic busy
);

  typedef enum {
    ST_IDLE,
    ST_ARMED,
    ST_SETUP,
    ST_SECOND
  } tfmc_state_t;

  tfmc_state_t state_reg;
  logic trigMeta_reg;
  logic trigSync_reg;
  logic trigPrev_reg;
  logic exposureOut_reg;
  logic frameDeliver_reg;
  logic frameDrop_reg;
  logic trigEdge;
  logic restart;
  logic expStart;
  logic expEnd;
  logic expActive;
  logic fStart;
  logic isFree;
  logic isFast;
  logic isPrecise;
  logic lateArm;
  logic seqArm;
  logic fastDone;
  logic frameDeliver_next;
  logic frameDrop_next;

  // ----------------------------------------
  // trigger synchroniser and edge
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      trigMeta_reg <= 1'b0;
      trigSync_reg <= 1'b0;
      trigPrev_reg <= 1'b0;
    end else begin
      trigMeta_reg <= triggerIn;
      trigSync_reg <= trigMeta_reg;
      trigPrev_reg <= trigSync_reg;
    end
  end

  assign trigEdge = trigSync_reg && !trigPrev_reg;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign isFree = (modeSel == tfmc_pkg::TFMC_MODE_FREE);
  assign isFast = (modeSel == tfmc_pkg::TFMC_MODE_FAST);
  assign isPrecise = (modeSel == tfmc_pkg::TFMC_MODE_PRECISE);

  // ----------------------------------------
  // exposure gating
  // ----------------------------------------
  // fast trigger on the exposure start still claims this frame
  assign lateArm = expStart && trigEdge && isFast && (state_reg == ST_IDLE);
  assign seqArm = expStart && (state_reg == ST_ARMED || state_reg == ST_SECOND);
  assign fastDone = expEnd && exposureOut_reg;

  // ----------------------------------------
  // sensor frame cycle
  // ----------------------------------------
  assign restart = trigEdge && isPrecise
                   && (state_reg == ST_IDLE);

  tfmc_frame_timer #(
    .FRAME_CYC(FRAME_CYC),
    .EXP_START(EXP_START),
    .EXP_LEN(EXP_LEN)
  ) u_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .restart(restart),
    .frameStart(fStart),
    .expStart(expStart),
    .expEnd(expEnd),
    .expActive(expActive)
  );

  // ----------------------------------------
  // trigger sequencing
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (trigEdge) begin
            if (modeSel == tfmc_pkg::TFMC_MODE_FAST) begin
              state_reg <= ST_ARMED;
            end else if (modeSel == tfmc_pkg::TFMC_MODE_PRECISE) begin
              state_reg <= ST_SETUP;
            end
          end
        end
        ST_ARMED: begin
          // waits for next exposure start; running one is not used
          if (fastDone) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_SETUP: begin
          if (expEnd) begin
            state_reg <= ST_SECOND;
          end
        end
        ST_SECOND: begin
          if (expEnd) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // exposure output
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      exposureOut_reg <= 1'b0;
    end else if (isFree) begin
      exposureOut_reg <= expActive;
    end else if (expEnd) begin
      exposureOut_reg <= 1'b0;
    end else if (seqArm) begin
      exposureOut_reg <= 1'b1;
    end else if (lateArm) begin
      exposureOut_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // delivery and drop
  // ----------------------------------------
  always_comb begin
    frameDeliver_next = 1'b0;
    frameDrop_next = 1'b0;
    if (expEnd) begin
      case (modeSel)
        tfmc_pkg::TFMC_MODE_FREE: begin
          frameDeliver_next = 1'b1;
        end
        tfmc_pkg::TFMC_MODE_FAST: begin
          frameDeliver_next = exposureOut_reg;
          frameDrop_next = !exposureOut_reg;
        end
        tfmc_pkg::TFMC_MODE_PRECISE: begin
          frameDeliver_next = (state_reg == ST_SECOND);
          frameDrop_next = (state_reg != ST_SECOND);
        end
        default: begin
          frameDrop_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      frameDeliver_reg <= 1'b0;
      frameDrop_reg <= 1'b0;
    end else begin
      frameDeliver_reg <= frameDeliver_next;
      frameDrop_reg <= frameDrop_next;
    end
  end

  assign exposureOut = exposureOut_reg;
  assign frameDeliver = frameDeliver_reg;
  assign frameDrop = frameDrop_reg;
  assign frameStart = fStart;
  assign sensorExposing = expActive;
  assign busy = (state_reg != ST_IDLE);

endmodule

// ==== tfmc_checker.sv ====
// Purpose: port checks for trigger control
// Assumes: short sim frame timing
// Notes: bound into tfmc_top
`timescale 1ns/1ns
module tfmc_checker #(
  parameter int FRAME_CYC = 200,
  parameter int EXP_START = 20,
  parameter int EXP_LEN = 30
) (
  // clock
  input wire logic core_clk,
  input wire logic nrst,
  // watched
  input wire tfmc_pkg::tfmc_mode_t modeSel,
  input wire logic triggerIn,
  input wire logic exposureOut,
  input wire logic frameStart,
  input wire logic sensorExposing,
  input wire logic frameDeliver,
  input wire logic frameDrop,
  input wire logic busy
);
  localparam int DROP_AT = EXP_START + EXP_LEN;
  localparam int EXP_AT = FRAME_CYC + EXP_START + 1;
  int sinceStart = 0;
  int sinceTrig = 0;
  wire logic isFree = modeSel == tfmc_pkg::TFMC_MODE_FREE;
  wire logic isPrec = modeSel == tfmc_pkg::TFMC_MODE_PRECISE;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // cycles since frame start and since accepted trigger
  always @(posedge core_clk) begin
    sinceStart <= frameStart ? 1 : sinceStart + 1;
    sinceTrig <= $rose(busy) ? 1 : sinceTrig + 1;
  end
  sequence precTrig;
    isPrec ##0 $rose(busy);
  endsequence
  sequence setupDrop;
    ##DROP_AT frameDrop;
  endsequence
  restart_trig_a: assert property (precTrig |-> frameStart) else $error("no restart");
  setup_drop_a: assert property (precTrig |-> !frameDeliver throughout setupDrop)
    else $error("setup frame not dropped");
  exact_delay_a: assert property (isPrec && $rose(exposureOut) |-> sinceTrig == EXP_AT)
    else $error("delivered exposure late or early");
  exp_offset_a: assert property ($rose(exposureOut) |-> sinceStart == EXP_START + 1)
    else $error("exposure start misplaced");
  pulse_end_a: assert property (frameDeliver || frameDrop |-> $fell(sensorExposing))
    else $error("pulse not at exposure end");
  free_every_a: assert property (isFree && $fell(sensorExposing) |-> frameDeliver)
    else $error("free frame not delivered");
  free_idle_a: assert property (isFree |-> !busy) else $error("free mode busy");
  seq_end_a: assert property ($fell(busy) |-> frameDeliver) else $error("busy fell early");
endmodule
bind tfmc_top tfmc_checker #(.FRAME_CYC(FRAME_CYC), .EXP_START(EXP_START), .EXP_LEN(EXP_LEN))
  tfmc_checker_inst (.core_clk, .nrst, .modeSel, .triggerIn, .exposureOut, .frameStart,
  .sensorExposing, .frameDeliver, .frameDrop, .busy);

// ==== tfmc_trig_src.sv ====
// Purpose: external trigger source model
// Assumes: fire is a one-cycle request
// Notes: pin stays high four cycles
`timescale 1ns/1ns
module tfmc_trig_src (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // request and pin
  input wire logic fire,
  output logic triggerIn
);
  logic [2:0] holdCnt;
  always_ff @(posedge core_clk) begin
    if (!nrst) holdCnt <= 3'h0;
    else if (fire) holdCnt <= 3'h4;
    else if (holdCnt != 3'h0) holdCnt <= holdCnt - 3'h1;
  end
  assign triggerIn = holdCnt != 3'h0;
endmodule

// ==== tb_top.sv ====
// Purpose: scenario bench for trigger control
// Assumes: short frame timing
// Notes: timing judged from pulse cycle stamps
`timescale 1ns/1ns
module tb_top;
  localparam int FC = 200;
  localparam int ES = 20;
  localparam int EL = 30;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic fire = 1'b0;
  tfmc_pkg::tfmc_mode_t modeSel = tfmc_pkg::TFMC_MODE_FREE;
  logic triggerIn, exposureOut, frameStart, sensorExposing, frameDeliver, frameDrop, busy;
  int badCount = 0, nCompared = 0, cyc = 0, nDel = 0, nDrop = 0;
  int tDel = 0, tDrop = 0, tStart = 0, dropStart = 0, tExp = 0;
  logic expPrev = 1'b0;
  always #5 core_clk = ~core_clk;
  tfmc_trig_src tfmc_trig_src_inst (.core_clk, .nrst, .fire, .triggerIn);
  tfmc_top #(.FRAME_CYC(FC), .EXP_START(ES), .EXP_LEN(EL)) tfmc_top_inst (.core_clk, .nrst,
    .modeSel, .triggerIn, .exposureOut, .frameStart, .sensorExposing, .frameDeliver,
    .frameDrop, .busy);
  // stamps taken where outputs are settled
  always @(negedge core_clk) begin
    cyc++;
    if (frameStart === 1'b1) tStart = cyc;
    if (exposureOut === 1'b1 && expPrev !== 1'b1) tExp = cyc;
    expPrev = exposureOut;
    if (frameDeliver === 1'b1) begin
      nDel++;
      tDel = cyc;
    end
    if (frameDrop === 1'b1) begin
      nDrop++;
      tDrop = cyc;
      dropStart = tStart;
    end
  end
  task automatic chk(input string what, input int expv, input int got);
    nCompared++;
    if (expv !== got) begin
      badCount++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, expv, got);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic set_mode(input tfmc_pkg::tfmc_mode_t m);
    @(posedge core_clk);
    nrst <= 1'b0;
    modeSel <= m;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
  endtask
  task automatic pulse(input int pre);
    repeat (pre) @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask
  task automatic wait_start();
    int i;
    @(negedge core_clk);
    for (i = 0; i < 1000 && frameStart !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    if (i == 1000) begin
      badCount++;
      give_verdict();
    end
  endtask
  task automatic free_run();
    int n0;
    set_mode(tfmc_pkg::TFMC_MODE_FREE);
    pulse(1);
    n0 = nDel;
    repeat (2 * FC) @(posedge core_clk);
    chk("free deliveries", 2, nDel - n0);
  endtask
  task automatic fast_run(input int pre, input int lag);
    int n0, t0;
    set_mode(tfmc_pkg::TFMC_MODE_FAST);
    wait_start();
    t0 = tStart;
    n0 = nDel;
    pulse(pre);
    repeat (3 * FC) @(posedge core_clk);
    chk("fast deliveries", 1, nDel - n0);
    chk("fast delay", lag + ES + EL, tDel - t0);
    chk("fast exposure", lag + ES + 1, tExp - t0);
  endtask
  task automatic precise_run();
    int n0, d0, t0;
    set_mode(tfmc_pkg::TFMC_MODE_PRECISE);
    wait_start();
    t0 = tStart;
    pulse(77);
    n0 = nDel;
    d0 = nDrop;
    pulse(100);
    repeat (FC) @(posedge core_clk);
    chk("precise drops", 1, nDrop - d0);
    chk("precise deliveries", 1, nDel - n0);
    chk("restart point", 77 + 5, dropStart - t0);
    chk("restart offset", ES + EL, tDrop - dropStart);
    chk("setup frame", FC, tDel - tDrop);
    chk("precise exposure", FC + ES + 1, tExp - dropStart);
  endtask
  initial begin
    #1000000;
    badCount++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    free_run();
    fast_run(1, 0);
    fast_run(ES + 5, FC);
    precise_run();
    give_verdict();
  end
endmodule
